// ### logic/idsf_core.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module idsf_core
	import idsf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic enable_i,
	input wire logic acknowledge_enable_i,
	input wire logic no_clock_stretch_i,
	input wire logic master_start_i,
	input wire logic byte_active_i,
	input wire logic byte_finished_i,
	input wire logic rx_byte_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_is_address_i,
	input wire logic pec_mismatch_i,
	input wire logic ack_arb_lost_i,
	input wire logic arb_lost_i,
	input wire logic nack_i,
	input wire logic tx_load_i,
	input wire logic tx_data_phase_i,
	input wire logic next_is_pec_i,
	output logic [7:0] tx_byte_o,
	output logic ack_o,
	output logic tx_buffer_empty_o,
	output logic rx_buffer_full_o,
	output logic master_mode_status_o
);

	// ----------------------------------------------------------------
	// state and decode signals
	// ----------------------------------------------------------------
	idsf_state_t s;
	idsf_state_t next_s;
	logic scl_f;
	logic sda_f;
	logic bus_req;
	logic wr_data;
	logic rd_data;
	logic wr_flags;
	logic start_cond;
	logic stop_cond;
	logic rx_data_byte;
	logic rx_overrun;
	logic rx_store;
	logic tx_underrun;
	logic slave_nostretch;

	function automatic logic [15:0] flag_word(input idsf_state_t st);
		logic [15:0] w;
		w = 16'h0000;
		w[PARITY_CHECK_ERROR_BIT] = st.parity_check_error;
		w[OVERRUN_BIT] = st.overrun;
		w[ACKNOWLEDGE_FAILURE_BIT] = st.acknowledge_failure;
		w[ARBITRATION_LOST_BIT] = st.arbitration_lost;
		w[BUS_CONDITION_ERROR_BIT] = st.bus_condition_error;
		w[TX_BUFFER_EMPTY_BIT] = st.tx_buffer_empty;
		w[RX_BUFFER_FULL_BIT] = st.rx_buffer_full;
		return w;
	endfunction : flag_word

	// ----------------------------------------------------------------
	// pin sampling
	// ----------------------------------------------------------------
	idsf_pin_sync u_scl_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.pin_i(scl_i),
		.level_o(scl_f)
	);

	idsf_pin_sync u_sda_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.pin_i(sda_i),
		.level_o(sda_f)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		wr_data = 1'b0;
		rd_data = 1'b0;
		wr_flags = 1'b0;
		bus_req = (avs_read_i | avs_write_i) & s.waitreq;
		start_cond = scl_f & s.sda_q & ~sda_f;
		stop_cond = scl_f & ~s.sda_q & sda_f;
		slave_nostretch = ~s.master_mode_status & no_clock_stretch_i;
		rx_data_byte = rx_byte_valid_i & ~rx_is_address_i;
		rx_overrun = rx_data_byte & ~ack_arb_lost_i & slave_nostretch
			& s.rx_buffer_full;
		rx_store = rx_data_byte & ~ack_arb_lost_i & ~rx_overrun;
		tx_underrun = tx_load_i & slave_nostretch & ~s.tx_written;
		next_s.sda_q = sda_f;
		next_s.waitreq = 1'b1;

		// bus slave, one answer cycle per request
		if (bus_req) begin
			next_s.waitreq = 1'b0;
			next_s.resp = RESP_OKAY;
			if (avs_address_i == BYTE_BUFFER_OFFSET) begin
				next_s.rdata = {24'h000000, s.data};
				wr_data = avs_write_i & avs_byteenable_i[0];
				rd_data = avs_read_i;
			end else if (avs_address_i == TRANSFER_FLAGS_OFFSET) begin
				next_s.rdata = {16'h0000, flag_word(s)};
				wr_flags = avs_write_i & avs_byteenable_i[1];
			end else begin
				next_s.rdata = 32'h00000000;
				next_s.resp = RESP_SLVERR;
			end
		end

		// buffer write and read side effects
		if (wr_data) begin
			next_s.data = avs_writedata_i[7:0];
			next_s.tx_written = 1'b1;
			if (!(s.first_pending | byte_finished_i)) begin
				next_s.tx_buffer_empty = 1'b0;
			end
			next_s.rx_buffer_full = 1'b0;
		end
		if (rd_data && !byte_finished_i) begin
			next_s.rx_buffer_full = 1'b0;
		end

		// error flags: write zero clears, one is ignored
		if (wr_flags) begin
			if (!avs_writedata_i[PARITY_CHECK_ERROR_BIT]) begin
				next_s.parity_check_error = 1'b0;
			end
			if (!avs_writedata_i[OVERRUN_BIT]) begin
				next_s.overrun = 1'b0;
			end
			if (!avs_writedata_i[ACKNOWLEDGE_FAILURE_BIT]) begin
				next_s.acknowledge_failure = 1'b0;
			end
			if (!avs_writedata_i[ARBITRATION_LOST_BIT]) begin
				next_s.arbitration_lost = 1'b0;
			end
			if (!avs_writedata_i[BUS_CONDITION_ERROR_BIT]) begin
				next_s.bus_condition_error = 1'b0;
			end
		end

		// start and stop conditions
		if (start_cond | stop_cond) begin
			next_s.tx_buffer_empty = 1'b0;
			if (byte_active_i) begin
				next_s.bus_condition_error = 1'b1;
			end
		end
		if (start_cond) begin
			next_s.first_pending = 1'b1;
		end

		// transmit side
		if (tx_load_i) begin
			next_s.tx_written = 1'b0;
			next_s.first_pending = 1'b0;
			if (tx_data_phase_i && !nack_i && !next_is_pec_i) begin
				next_s.tx_buffer_empty = 1'b1;
			end
		end
		if (tx_underrun) begin
			next_s.overrun = 1'b1;
		end
		if (nack_i) begin
			next_s.acknowledge_failure = 1'b1;
		end

		// receive side
		if (rx_byte_valid_i) begin
			next_s.ack = acknowledge_enable_i & ~pec_mismatch_i;
			if (pec_mismatch_i) begin
				next_s.parity_check_error = 1'b1;
			end
		end
		if (rx_overrun) begin
			next_s.overrun = 1'b1;
		end
		if (rx_store) begin
			next_s.data = rx_byte_i;
			next_s.rx_buffer_full = 1'b1;
		end

		// mastership
		if (master_start_i) begin
			next_s.master_mode_status = 1'b1;
		end
		if (arb_lost_i | (rx_byte_valid_i & ack_arb_lost_i)) begin
			next_s.arbitration_lost = 1'b1;
			next_s.master_mode_status = 1'b0;
		end

		// peripheral disabled
		if (!enable_i) begin
			next_s.tx_buffer_empty = 1'b0;
			next_s.rx_buffer_full = 1'b0;
			next_s.parity_check_error = 1'b0;
			next_s.overrun = 1'b0;
			next_s.acknowledge_failure = 1'b0;
			next_s.arbitration_lost = 1'b0;
			next_s.bus_condition_error = 1'b0;
			next_s.tx_written = 1'b0;
			next_s.first_pending = 1'b0;
			next_s.master_mode_status = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.data <= BYTE_BUFFER_RESET;
			s.sda_q <= 1'b1;
			s.waitreq <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = s.waitreq;
	assign avs_response_o = s.resp;
	assign tx_byte_o = s.data;
	assign ack_o = s.ack;
	assign tx_buffer_empty_o = s.tx_buffer_empty;
	assign rx_buffer_full_o = s.rx_buffer_full;
	assign master_mode_status_o = s.master_mode_status;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_DATA_RESERVED_ZERO: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(bus_req && avs_read_i && avs_address_i == BYTE_BUFFER_OFFSET)
		|=> (!avs_waitrequest_o && avs_readdata_o[31:8] == 24'h000000
		&& avs_readdata_o[7:0] == $past(tx_byte_o)))
		else $error("buffer read shows wrong data or reserved bits");

	AST_ADDRESS_NOT_STORED: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(rx_byte_valid_i && rx_is_address_i && !wr_data)
		|=> $stable(tx_byte_o))
		else $error("address byte entered the buffer");

	AST_WRITE_ALWAYS_TAKEN: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(wr_data && !rx_store)
		|=> (tx_byte_o == $past(avs_writedata_i[7:0])))
		else $error("buffer write lost");

	AST_ARB_ACK_DISCARD: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(rx_byte_valid_i && ack_arb_lost_i && !wr_data && !rd_data
		&& enable_i)
		|=> ($stable(tx_byte_o) && $stable(rx_buffer_full_o)))
		else $error("byte kept after arbitration loss in ack");

	AST_ERROR_WRITE_ZERO: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(wr_flags && !avs_writedata_i[BUS_CONDITION_ERROR_BIT]
		&& !start_cond && !stop_cond)
		|=> !s.bus_condition_error)
		else $error("bus error flag not cleared by zero write");

	AST_DISABLE_CLEARS: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		!enable_i |=> (flag_word(s) == 16'h0000 && !master_mode_status_o))
		else $error("flags remain while disabled");

	AST_PEC_NACK: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(rx_byte_valid_i && enable_i)
		|=> (ack_o == ($past(acknowledge_enable_i) && !$past(pec_mismatch_i))
		&& (s.parity_check_error || !$past(pec_mismatch_i))))
		else $error("ack answer does not follow parity check");

	AST_OVERRUN_LOSES_BYTE: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(rx_overrun && enable_i && !wr_data)
		|=> (s.overrun && $stable(tx_byte_o)))
		else $error("overrun not flagged or byte not dropped");

	AST_ARB_DROPS_MASTER: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(arb_lost_i && enable_i)
		|=> (!master_mode_status_o && s.arbitration_lost))
		else $error("arbitration loss kept master mode");

	AST_START_CLEARS_TXE: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(start_cond && !tx_load_i) |=> !tx_buffer_empty_o)
		else $error("empty flag survived start condition");

	AST_READ_CLEARS_RXNE: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(rd_data && !byte_finished_i && !rx_store) |=> !rx_buffer_full_o)
		else $error("buffer read did not clear full flag");

	AST_READ_KEEPS_RXNE: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(rd_data && byte_finished_i && rx_buffer_full_o && enable_i)
		|=> rx_buffer_full_o)
		else $error("full flag cleared while byte finished");

	AST_UNDERRUN_RESENDS: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(tx_underrun && enable_i && !wr_data && !rx_store)
		|=> (s.overrun && $stable(tx_byte_o)))
		else $error("underrun not flagged or byte changed");

	AST_BUS_ERROR_SET: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		((start_cond || stop_cond) && byte_active_i && enable_i)
		|=> s.bus_condition_error)
		else $error("misplaced start or stop not flagged");

	AST_TXE_SET_DATA: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(tx_load_i && enable_i && tx_data_phase_i && !nack_i
		&& !next_is_pec_i) |=> tx_buffer_empty_o)
		else $error("empty flag not set after data byte taken");

	AST_TXE_HELD_NACK: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(tx_load_i && (nack_i || next_is_pec_i)
		&& !tx_buffer_empty_o)
		|=> !tx_buffer_empty_o)
		else $error("empty flag set after nack or before check byte");

	AST_FLAG_WRITE_ONE: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(wr_flags && avs_writedata_i[PARITY_CHECK_ERROR_BIT]
		&& s.parity_check_error && enable_i) |=> s.parity_check_error)
		else $error("parity error flag cleared by a one write");

endmodule : idsf_core

// ### logic/idsf_pin_sync.sv
`timescale 1ns/1ps
module idsf_pin_sync
	import idsf_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic pin_i,
	output logic level_o
);

	// ----------------------------------------------------------------
	// three stages, change taken once last two agree
	// ----------------------------------------------------------------
	idsf_sync_t s;
	idsf_sync_t next_s;

	always_comb begin
		next_s = s;
		next_s.s1 = pin_i;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		if (s.s2 == s.s3) begin
			next_s.level = s.s3;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1};
		end else begin
			s <= next_s;
		end
	end

	assign level_o = s.level;

endmodule : idsf_pin_sync

// ### logic/idsf_pkg.sv
// Notes on behaviour
// - one 8-bit buffer in bits 7:0 for both directions; bits 31:8 reserved.
// - as slave, a received address byte never enters the buffer.
// - software may write the buffer even while tx_buffer_empty is zero.
// - byte received when arbitration is lost in the ack pulse is discarded.
// - error flags in bits 12:8 clear when software writes zero to them.
// - peripheral enable low clears every flag of transfer_flags.
// - parity mismatch sets parity_check_error and forces NACK; else ACK per enable.
// - slave without stretching: byte into unread buffer sets overrun, byte lost.
// - slave sender without stretching and no new byte: underrun, resend old byte.
// - arbitration loss sets arbitration_lost and drops master mode.
// - start or stop at an illegal point sets bus_condition_error.
// - tx_buffer_empty clears on buffer write and on start or stop.
// - tx_buffer_empty sets when emptied during data, never during address.
// - tx_buffer_empty not set after NACK or before the check byte.
// - first byte write, or write while byte_finished, keeps tx_buffer_empty.
// - rx_buffer_full clears when software reads or writes the buffer.
// - rx_buffer_full sets when a data byte is held, not for addresses.
// - rx_buffer_full is not set when arbitration is lost.
// - read while byte_finished is set leaves rx_buffer_full set.
package idsf_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] BYTE_BUFFER_OFFSET = 8'h10;
	localparam logic [7:0] TRANSFER_FLAGS_OFFSET = 8'h14;
	localparam logic [7:0] BYTE_BUFFER_RESET = 8'h00;

	// ----------------------------------------------------------------
	// transfer_flags field positions
	// ----------------------------------------------------------------
	localparam int PARITY_CHECK_ERROR_BIT = 12;
	localparam int OVERRUN_BIT = 11;
	localparam int ACKNOWLEDGE_FAILURE_BIT = 10;
	localparam int ARBITRATION_LOST_BIT = 9;
	localparam int BUS_CONDITION_ERROR_BIT = 8;
	localparam int TX_BUFFER_EMPTY_BIT = 7;
	localparam int RX_BUFFER_FULL_BIT = 6;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} idsf_sync_t;

	typedef struct packed {
		logic [7:0] data;
		logic tx_buffer_empty;
		logic rx_buffer_full;
		logic parity_check_error;
		logic overrun;
		logic acknowledge_failure;
		logic arbitration_lost;
		logic bus_condition_error;
		logic tx_written;
		logic first_pending;
		logic master_mode_status;
		logic ack;
		logic sda_q;
		logic waitreq;
		logic [1:0] resp;
		logic [31:0] rdata;
	} idsf_state_t;

endpackage : idsf_pkg

// ### verification/idsf_bus_model.sv
`timescale 1ns/1ps
module idsf_bus_model (
	input wire logic go_i,
	output logic scl_o,
	output logic sda_o,
	output logic busy_o
);
	// ----------------------------------------------------------------
	// frame generator
	// ----------------------------------------------------------------
	// lines idle high by pull-up; clock stands still outside frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		busy_o = 1'b0;
	end

	// start, two clock pulses, stop; 125 ns link clock
	always @(posedge go_i) begin
		busy_o = 1'b1;
		#62.5 sda_o = 1'b0;
		#62.5 scl_o = 1'b0;
		repeat (2) begin
			#62.5 scl_o = 1'b1;
			#62.5 scl_o = 1'b0;
		end
		#62.5 scl_o = 1'b1;
		#62.5 sda_o = 1'b1;
		busy_o = 1'b0;
	end
endmodule : idsf_bus_model

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import idsf_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'h0;
	logic en = 1'b1;
	logic acknowledge_enable = 1'b1;
	logic nstr = 1'b0;
	logic bact = 1'b0;
	logic bfin = 1'b0;
	logic rxa = 1'b0;
	logic pec = 1'b0;
	logic aal = 1'b0;
	logic dph = 1'b1;
	logic npec = 1'b0;
	logic go = 1'b0;
	logic [4:0] pl = 5'h00;
	logic [7:0] rxb = 8'h00;
	logic [31:0] rdat;
	logic [31:0] got_d;
	logic [1:0] rsp;
	logic [1:0] got_r;
	logic [7:0] txb;
	logic wreq, scl, sda, busy, ack, txe, rxf, mst;
	int errors = 0;
	int n_compared = 0;

	idsf_core idsf_core_i (.mclk_i(clk), .rstn_i(rst_n),
		.avs_address_i(adr), .avs_read_i(rd_en), .avs_write_i(wr_en),
		.avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.avs_response_o(rsp), .scl_i(scl), .sda_i(sda), .enable_i(en),
		.acknowledge_enable_i(acknowledge_enable), .no_clock_stretch_i(nstr),
		.master_start_i(pl[0]), .byte_active_i(bact),
		.byte_finished_i(bfin), .rx_byte_valid_i(pl[4]), .rx_byte_i(rxb),
		.rx_is_address_i(rxa), .pec_mismatch_i(pec),
		.ack_arb_lost_i(aal), .arb_lost_i(pl[1]), .nack_i(pl[2]),
		.tx_load_i(pl[3]), .tx_data_phase_i(dph), .next_is_pec_i(npec),
		.tx_byte_o(txb), .ack_o(ack), .tx_buffer_empty_o(txe),
		.rx_buffer_full_o(rxf), .master_mode_status_o(mst));

	idsf_bus_model idsf_bus_model_i (.go_i(go), .scl_o(scl), .sda_o(sda),
		.busy_o(busy));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic acc(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr_en <= w;
		rd_en <= !w;
		wd <= d;
		be <= b;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) errors++;
		got_d = rdat;
		got_r = rsp;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		#1;
	endtask : acc

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		acc(a, 1'b0, 32'h0, 4'hf);
		chk(got_d, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		acc(a, 1'b1, d, b);
	endtask : wr

	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		pl <= m;
		@(posedge clk);
		pl <= 5'h00;
		#1;
	endtask : pulse

	task automatic rx(input logic [7:0] b, input logic [2:0] q);
		@(posedge clk);
		rxb <= b;
		{rxa, pec, aal} <= q;
		pulse(5'h10);
	endtask : rx

	task automatic frame();
		int n;
		n = 0;
		@(posedge clk) go <= 1'b1;
		@(posedge clk);
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) errors++;
		repeat (6) @(posedge clk);
		go <= 1'b0;
	endtask : frame

	task automatic final_report();
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial forever #5 clk = ~clk;

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h20, 32'h0);
		chk({30'h0, got_r}, 32'h2);
		wr(8'h10, 32'h0000ffa5, 4'hf);
		rd(8'h10, 32'ha5);
		wr(8'h10, 32'h5a, 4'h2);
		rd(8'h10, 32'ha5);
		rx(8'h3c, 3'b000);
		chk({23'h0, ack, txb}, 32'h13c);
		rd(8'h14, 32'h40);
		rd(8'h10, 32'h3c);
		rd(8'h14, 32'h0);
		rx(8'h77, 3'b100);
		chk({23'h0, rxf, txb}, 32'h3c);
		rx(8'h66, 3'b001);
		chk({23'h0, rxf, txb}, 32'h3c);
		wr(8'h14, 32'h0, 4'h2);
		rx(8'h12, 3'b010);
		chk({31'h0, ack}, 32'h0);
		wr(8'h14, 32'h1fff, 4'h3);
		rd(8'h14, 32'h1040);
		rd(8'h10, 32'h12);
		wr(8'h14, 32'h0, 4'h2);
		rd(8'h14, 32'h0);
		rx(8'h21, 3'b000);
		wr(8'h10, 32'h30, 4'h1);
		chk({31'h0, rxf}, 32'h0);
		@(posedge clk) nstr <= 1'b1;
		rx(8'h11, 3'b000);
		rx(8'h22, 3'b000);
		rd(8'h14, 32'h0840);
		chk({24'h0, txb}, 32'h11);
		@(posedge clk) bfin <= 1'b1;
		rd(8'h10, 32'h11);
		chk({31'h0, rxf}, 32'h1);
		@(posedge clk) bfin <= 1'b0;
		rd(8'h10, 32'h11);
		wr(8'h14, 32'h0, 4'h2);
		pulse(5'h01);
		chk({31'h0, mst}, 32'h1);
		pulse(5'h02);
		chk({31'h0, mst}, 32'h0);
		pulse(5'h04);
		wr(8'h14, 32'h0, 4'h1);
		rd(8'h14, 32'h0600);
		wr(8'h14, 32'h0, 4'h2);
		pulse(5'h08);
		chk({31'h0, txe}, 32'h1);
		pulse(5'h08);
		rd(8'h14, 32'h0880);
		chk({24'h0, txb}, 32'h11);
		@(posedge clk) bfin <= 1'b1;
		wr(8'h10, 32'h44, 4'h1);
		chk({31'h0, txe}, 32'h1);
		@(posedge clk) bfin <= 1'b0;
		wr(8'h10, 32'h45, 4'h1);
		chk({31'h0, txe}, 32'h0);
		@(posedge clk) dph <= 1'b0;
		pulse(5'h08);
		chk({31'h0, txe}, 32'h0);
		@(posedge clk) dph <= 1'b1;
		@(posedge clk) npec <= 1'b1;
		pulse(5'h08);
		chk({31'h0, txe}, 32'h0);
		@(posedge clk) npec <= 1'b0;
		pulse(5'h0c);
		chk({31'h0, txe}, 32'h0);
		pulse(5'h08);
		wr(8'h14, 32'h0, 4'h2);
		@(posedge clk) bact <= 1'b1;
		frame();
		rd(8'h14, 32'h0100);
		@(posedge clk) bact <= 1'b0;
		pulse(5'h05);
		rx(8'h99, 3'b000);
		@(posedge clk) en <= 1'b0;
		@(posedge clk) en <= 1'b1;
		rd(8'h14, 32'h0);
		chk({31'h0, mst}, 32'h0);
		final_report();
	end
endmodule : tb_top
